// >>> hw/dma_channel_control_regs.sv
`timescale 1ns/100ps
`include "dma_cc_params.svh"
module dma_channel_control_regs #(
  parameter int CHANNELS = 2
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // Register port
  input wire logic [31:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // Request sources
  input wire logic [CHANNELS-1:0] transfer_request_pin_n_i,
  input wire logic timer0_match_req_i,
  input wire logic timer1_match_req_i,
  input wire logic timer2_match_req_i,
  input wire logic converter_end_req_i,
  input wire logic serial0_tx_req_i,
  input wire logic serial0_rx_req_i,
  input wire logic serial1_tx_req_i,
  input wire logic serial1_rx_req_i,
  // System events
  input wire logic addr_fault_i,
  input wire logic nmi_i,
  input wire logic standby_i,
  // Transfer engine handshake
  input wire logic [CHANNELS-1:0] xfer_ack_i,
  output logic [CHANNELS-1:0] xfer_req_o,
  output logic [CHANNELS-1:0][31:0] xfer_src_addr_o,
  output logic [CHANNELS-1:0][31:0] xfer_dst_addr_o,
  output logic [CHANNELS-1:0][1:0] xfer_unit_size_o,
  output logic [CHANNELS-1:0] xfer_single_o,
  output logic [CHANNELS-1:0] xfer_to_device_o,
  output logic [CHANNELS-1:0] xfer_burst_o,
  // Interrupt
  output logic irq_o
);
  import dma_cc_pkg::*;

  if (CHANNELS < 1 || CHANNELS > 2) begin : g_bad_channels
    $error("CHANNELS must be 1 or 2");
  end

  //////////////////////////////////////////////////////////////////////////
  // State

  logic [CHANNELS-1:0][31:0] ctrl_ff, nxt_ctrl;
  logic [CHANNELS-1:0][31:0] src_ff, nxt_src;
  logic [CHANNELS-1:0][31:0] dst_ff, nxt_dst;
  logic [CHANNELS-1:0][`COUNT_W-1:0] cnt_ff, nxt_cnt;
  logic [CHANNELS-1:0] pend_ff, nxt_pend;
  logic [CHANNELS-1:0] done_arm_ff, nxt_done_arm;
  ch_state_e [CHANNELS-1:0] st_ff, nxt_st;
  logic [15:0] glob_ff, nxt_glob;
  logic ae_arm_ff, nxt_ae_arm;
  logic nmi_arm_ff, nxt_nmi_arm;
  logic [3:0] stat_ff, nxt_stat;
  logic [3:0] mask_ff, nxt_mask;
  logic [31:0] rdata_ff, nxt_rdata;

  logic [CHANNELS-1:0] pin_req, sel_req, sel_valid, sel_single, sel_todev;
  logic [CHANNELS-1:0] run, done_evt;

  //////////////////////////////////////////////////////////////////////////
  // Request front end

  for (genvar c = 0; c < CHANNELS; c++) begin : g_req
    req_pin_sense u_pin (
      .mclk_i(mclk_i),
      .reset_n_i(reset_n_i),
      .pin_n_i(transfer_request_pin_n_i[c]),
      .edge_mode_i(ctrl_ff[c][`BIT_SENSE]),
      .req_o(pin_req[c])
    );
    req_select u_sel (
      .code_i(ctrl_ff[c][`BIT_REQ_LO+3:`BIT_REQ_LO]),
      .pin_req_i(pin_req[c]),
      .timer0_match_req_i(timer0_match_req_i),
      .timer1_match_req_i(timer1_match_req_i),
      .timer2_match_req_i(timer2_match_req_i),
      .converter_end_req_i(converter_end_req_i),
      .serial0_tx_req_i(serial0_tx_req_i),
      .serial0_rx_req_i(serial0_rx_req_i),
      .serial1_tx_req_i(serial1_tx_req_i),
      .serial1_rx_req_i(serial1_rx_req_i),
      .req_o(sel_req[c]),
      .valid_o(sel_valid[c]),
      .single_o(sel_single[c]),
      .to_device_o(sel_todev[c])
    );
  end

  function automatic logic hit(input logic [31:0] a, input logic [31:0] b);
    hit = (a == b);
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Channel sequencing and register writes

  always_comb begin
    logic [31:0] base;
    logic [`COUNT_W-1:0] left;
    base = 32'h0;
    left = '0;
    nxt_ctrl = ctrl_ff;
    nxt_src = src_ff;
    nxt_dst = dst_ff;
    nxt_cnt = cnt_ff;
    nxt_pend = pend_ff;
    nxt_done_arm = done_arm_ff;
    nxt_st = st_ff;
    run = '0;
    done_evt = '0;
    for (int c = 0; c < CHANNELS; c++) begin
      base = c[0] ? `CH_STRIDE : 32'h0;
      // Halt flags and master enable gate every channel
      run[c] = glob_ff[`BIT_GEN] & ~glob_ff[`BIT_AE] &
               ~glob_ff[`BIT_NMI] & ctrl_ff[c][`BIT_CH_EN] &
               ~ctrl_ff[c][`BIT_DONE] & (cnt_ff[c] != '0) & sel_valid[c];
      // Pending only lives while the channel may run; a stale one
      // would otherwise start a unit under a newly written code
      nxt_pend[c] = run[c] & ((pend_ff[c] & ~xfer_ack_i[c]) | sel_req[c]);
      case (st_ff[c])
        CH_IDLE: begin
          if (run[c] && pend_ff[c]) begin
            nxt_st[c] = CH_REQ;
          end
        end
        CH_REQ: begin
          if (xfer_ack_i[c]) begin
            left = cnt_ff[c] - `COUNT_W'(1);
            nxt_cnt[c] = left;
            nxt_src[c] = step_ptr(src_ff[c],
                ctrl_ff[c][`BIT_SRC_LO+1:`BIT_SRC_LO],
                ctrl_ff[c][`BIT_SIZE_LO+1:`BIT_SIZE_LO]);
            nxt_dst[c] = step_ptr(dst_ff[c],
                ctrl_ff[c][`BIT_DST_LO+1:`BIT_DST_LO],
                ctrl_ff[c][`BIT_SIZE_LO+1:`BIT_SIZE_LO]);
            done_evt[c] = (left == '0);
            // Cycle steal hands the bus back after every unit
            if (done_evt[c] || !ctrl_ff[c][`BIT_BURST]) begin
              nxt_st[c] = CH_IDLE;
            end
          end else if (!run[c]) begin
            nxt_st[c] = CH_IDLE;
          end
        end
        default: nxt_st[c] = CH_IDLE;
      endcase
      if (rd_i && hit(addr_i, `OFF_CTRL0 + base) &&
          ctrl_ff[c][`BIT_DONE]) begin
        nxt_done_arm[c] = 1'b1;
      end
      if (wr_i && hit(addr_i, `OFF_SRC0 + base)) begin
        nxt_src[c] = wdata_i;
      end
      if (wr_i && hit(addr_i, `OFF_DST0 + base)) begin
        nxt_dst[c] = wdata_i;
      end
      if (wr_i && hit(addr_i, `OFF_CNT0 + base)) begin
        nxt_cnt[c] = wdata_i[`COUNT_W-1:0];
      end
      if (wr_i && hit(addr_i, `OFF_CTRL0 + base)) begin
        nxt_ctrl[c] = (wdata_i & `CTRL_WR_MASK) |
                      (ctrl_ff[c] & ~`CTRL_WR_MASK);
        if (!wdata_i[`BIT_DONE] && done_arm_ff[c]) begin
          nxt_ctrl[c][`BIT_DONE] = 1'b0;
          nxt_done_arm[c] = 1'b0;
        end
      end
      if (standby_i) begin
        nxt_ctrl[c][`BIT_DONE] = 1'b0;
        nxt_done_arm[c] = 1'b0;
      end
      // Completion beats a clear in the same cycle
      if (done_evt[c]) begin
        nxt_ctrl[c][`BIT_DONE] = 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Global register, status, mask and read data

  always_comb begin
    logic [31:0] base;
    base = 32'h0;
    nxt_glob = glob_ff;
    nxt_ae_arm = ae_arm_ff;
    nxt_nmi_arm = nmi_arm_ff;
    nxt_stat = stat_ff;
    nxt_mask = mask_ff;
    nxt_rdata = 32'h0;
    if (rd_i) begin
      if (hit(addr_i, `OFF_GLOBAL)) begin
        nxt_rdata = {16'h0, glob_ff};
        nxt_ae_arm = ae_arm_ff | glob_ff[`BIT_AE];
        nxt_nmi_arm = nmi_arm_ff | glob_ff[`BIT_NMI];
      end else if (hit(addr_i, `OFF_STATUS)) begin
        nxt_rdata = {28'h0, stat_ff};
        nxt_stat = 4'h0;
      end else if (hit(addr_i, `OFF_MASK)) begin
        nxt_rdata = {28'h0, mask_ff};
      end else begin
        for (int c = 0; c < CHANNELS; c++) begin
          base = c[0] ? `CH_STRIDE : 32'h0;
          if (hit(addr_i, `OFF_SRC0 + base)) begin
            nxt_rdata = src_ff[c];
          end else if (hit(addr_i, `OFF_DST0 + base)) begin
            nxt_rdata = dst_ff[c];
          end else if (hit(addr_i, `OFF_CNT0 + base)) begin
            nxt_rdata = {{(32-`COUNT_W){1'b0}}, cnt_ff[c]};
          end else if (hit(addr_i, `OFF_CTRL0 + base)) begin
            nxt_rdata = ctrl_ff[c];
          end
        end
      end
    end
    if (wr_i) begin
      if (hit(addr_i, `OFF_GLOBAL)) begin
        nxt_glob[`BIT_GEN] = wdata_i[`BIT_GEN];
        // A one written to either flag is ignored
        if (!wdata_i[`BIT_AE] && ae_arm_ff) begin
          nxt_glob[`BIT_AE] = 1'b0;
          nxt_ae_arm = 1'b0;
        end
        if (!wdata_i[`BIT_NMI] && nmi_arm_ff) begin
          nxt_glob[`BIT_NMI] = 1'b0;
          nxt_nmi_arm = 1'b0;
        end
      end else if (hit(addr_i, `OFF_MASK)) begin
        nxt_mask = wdata_i[3:0];
      end
    end
    if (addr_fault_i) begin
      nxt_glob[`BIT_AE] = 1'b1;
      nxt_stat[`ST_AE] = 1'b1;
    end
    if (nmi_i) begin
      nxt_glob[`BIT_NMI] = 1'b1;
      nxt_stat[`ST_NMI] = 1'b1;
    end
    for (int c = 0; c < CHANNELS; c++) begin
      if (done_evt[c] && ctrl_ff[c][`BIT_IRQ_EN]) begin
        nxt_stat[c] = 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      for (int c = 0; c < CHANNELS; c++) begin
        ctrl_ff[c] <= `CTRL_RST;
        src_ff[c] <= 32'h0;
        dst_ff[c] <= 32'h0;
        cnt_ff[c] <= '0;
        st_ff[c] <= CH_IDLE;
      end
      pend_ff <= '0;
      done_arm_ff <= '0;
      glob_ff <= `GLOBAL_RST;
      ae_arm_ff <= 1'b0;
      nmi_arm_ff <= 1'b0;
      stat_ff <= 4'h0;
      mask_ff <= 4'h0;
      rdata_ff <= 32'h0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      src_ff <= nxt_src;
      dst_ff <= nxt_dst;
      cnt_ff <= nxt_cnt;
      st_ff <= nxt_st;
      pend_ff <= nxt_pend;
      done_arm_ff <= nxt_done_arm;
      glob_ff <= nxt_glob;
      ae_arm_ff <= nxt_ae_arm;
      nmi_arm_ff <= nxt_nmi_arm;
      stat_ff <= nxt_stat;
      mask_ff <= nxt_mask;
      rdata_ff <= nxt_rdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs

  always_comb begin
    for (int c = 0; c < CHANNELS; c++) begin
      xfer_req_o[c] = (st_ff[c] == CH_REQ);
      xfer_unit_size_o[c] = ctrl_ff[c][`BIT_SIZE_LO+1:`BIT_SIZE_LO];
      xfer_burst_o[c] = ctrl_ff[c][`BIT_BURST];
    end
  end

  assign xfer_src_addr_o = src_ff;
  assign xfer_dst_addr_o = dst_ff;
  assign xfer_single_o = sel_single;
  assign xfer_to_device_o = sel_todev;
  assign rdata_o = rdata_ff;
  assign irq_o = |(stat_ff & mask_ff);

endmodule

// >>> hw/dma_cc_params.svh
`ifndef DMA_CC_PARAMS_SVH
`define DMA_CC_PARAMS_SVH

`define OFF_GLOBAL 32'hffff86b0
`define OFF_STATUS 32'hffff86b4
`define OFF_MASK 32'hffff86b8
`define OFF_SRC0 32'hffff86c0
`define OFF_DST0 32'hffff86c4
`define OFF_CNT0 32'hffff86c8
`define OFF_CTRL0 32'hffff86cc
`define CH_STRIDE 32'h00000010

`define BIT_CH_EN 0
`define BIT_DONE 1
`define BIT_IRQ_EN 2
`define BIT_SIZE_LO 3
`define BIT_BURST 5
`define BIT_SENSE 6
`define BIT_REQ_LO 8
`define BIT_SRC_LO 12
`define BIT_DST_LO 14
`define CTRL_WR_MASK 32'h0007ff7d
`define CTRL_RST 32'h00000000

`define BIT_GEN 0
`define BIT_NMI 1
`define BIT_AE 2
`define GLOBAL_RST 16'h0000

`define ST_AE 2
`define ST_NMI 3
`define COUNT_W 16

`endif

// >>> hw/dma_cc_pkg.sv
package dma_cc_pkg;

  typedef enum logic [3:0] {
    RQ_PIN_DUAL = 4'h0,
    RQ_PIN_TO_DEV = 4'h2,
    RQ_PIN_FROM_DEV = 4'h3,
    RQ_AUTO = 4'h4,
    RQ_TIMER0 = 4'h6,
    RQ_TIMER1 = 4'h7,
    RQ_TIMER2 = 4'h8,
    RQ_CONV = 4'hb,
    RQ_SER0_TX = 4'hc,
    RQ_SER0_RX = 4'hd,
    RQ_SER1_TX = 4'he,
    RQ_SER1_RX = 4'hf
  } req_src_e;

  typedef enum logic [1:0] {
    STEP_FIXED = 2'h0,
    STEP_INC = 2'h1,
    STEP_DEC = 2'h2
  } step_mode_e;

  typedef enum logic [1:0] {
    CH_IDLE = 2'h1,
    CH_REQ = 2'h2
  } ch_state_e;

  // Unit size code to byte step; barred size code yields no step
  function automatic logic [31:0] unit_bytes(input logic [1:0] size);
    unit_bytes = (size == 2'h0) ? 32'h1 :
                 (size == 2'h1) ? 32'h2 :
                 (size == 2'h2) ? 32'h4 : 32'h0;
  endfunction

  function automatic logic [31:0] step_ptr(input logic [31:0] ptr,
      input logic [1:0] mode, input logic [1:0] size);
    logic [31:0] amt;
    amt = unit_bytes(size);
    if (mode == STEP_INC) begin
      step_ptr = ptr + amt;
    end else if (mode == STEP_DEC) begin
      step_ptr = ptr - amt;
    end else begin
      step_ptr = ptr;
    end
  endfunction

endpackage

// >>> hw/req_pin_sense.sv
`timescale 1ns/100ps
module req_pin_sense (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // Pin and mode
  input wire logic pin_n_i,
  input wire logic edge_mode_i,
  // Detected request
  output logic req_o
);

  logic s1_ff, s2_ff, s3_ff, lvl_ff;
  logic nxt_lvl;

  always_comb begin
    nxt_lvl = (s2_ff == s3_ff) ? s2_ff : lvl_ff;
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      s1_ff <= 1'b1;
      s2_ff <= 1'b1;
      s3_ff <= 1'b1;
      lvl_ff <= 1'b1;
    end else begin
      s1_ff <= pin_n_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      lvl_ff <= nxt_lvl;
    end
  end

  // Edge mode gives one pulse per agreed high-to-low change
  assign req_o = edge_mode_i ? (lvl_ff & ~nxt_lvl) : ~lvl_ff;

endmodule

// >>> hw/req_select.sv
`timescale 1ns/100ps
module req_select (
  // Selection
  input wire logic [3:0] code_i,
  // Candidate sources
  input wire logic pin_req_i,
  input wire logic timer0_match_req_i,
  input wire logic timer1_match_req_i,
  input wire logic timer2_match_req_i,
  input wire logic converter_end_req_i,
  input wire logic serial0_tx_req_i,
  input wire logic serial0_rx_req_i,
  input wire logic serial1_tx_req_i,
  input wire logic serial1_rx_req_i,
  // Decoded request and mode
  output logic req_o,
  output logic valid_o,
  output logic single_o,
  output logic to_device_o
);
  import dma_cc_pkg::*;

  always_comb begin
    req_o = 1'b0;
    valid_o = 1'b1;
    single_o = 1'b0;
    to_device_o = 1'b0;
    case (code_i)
      RQ_PIN_DUAL: req_o = pin_req_i;
      RQ_PIN_TO_DEV: begin
        req_o = pin_req_i;
        single_o = 1'b1;
        to_device_o = 1'b1;
      end
      RQ_PIN_FROM_DEV: begin
        req_o = pin_req_i;
        single_o = 1'b1;
      end
      RQ_AUTO: req_o = 1'b1;
      RQ_TIMER0: req_o = timer0_match_req_i;
      RQ_TIMER1: req_o = timer1_match_req_i;
      RQ_TIMER2: req_o = timer2_match_req_i;
      RQ_CONV: req_o = converter_end_req_i;
      RQ_SER0_TX: req_o = serial0_tx_req_i;
      RQ_SER0_RX: req_o = serial0_rx_req_i;
      RQ_SER1_TX: req_o = serial1_tx_req_i;
      RQ_SER1_RX: req_o = serial1_rx_req_i;
      default: valid_o = 1'b0;
    endcase
  end

endmodule

// >>> testbench/xfer_engine_model.sv
`timescale 1ns/100ps
module xfer_engine_model (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // Engine handshake
  input wire logic [1:0] req_i,
  input wire logic slow_i,
  output logic [1:0] ack_o
);
  logic [1:0][1:0] wait_ff;
  always_ff @(posedge mclk_i) begin
    for (int c = 0; c < 2; c++) begin
      if (!reset_n_i || !req_i[c] || ack_o[c]) begin
        ack_o[c] <= 1'b0;
        wait_ff[c] <= 2'h0;
      end else if (!slow_i || wait_ff[c] == 2'h3) begin
        ack_o[c] <= 1'b1; // One unit per pulse
      end else begin
        wait_ff[c] <= wait_ff[c] + 2'h1;
      end
    end
  end
endmodule

// >>> testbench/dma_cc_chk.sv
`timescale 1ns/100ps
`include "dma_cc_params.svh"
module dma_cc_chk #(
  parameter int CHANNELS = 2
) (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic [31:0] addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic addr_fault_i,
  input wire logic nmi_i,
  input wire logic [CHANNELS-1:0] xfer_ack_i,
  input wire logic [CHANNELS-1:0] xfer_req_o,
  input wire logic [CHANNELS-1:0][31:0] xfer_src_addr_o,
  input wire logic [CHANNELS-1:0][31:0] xfer_dst_addr_o,
  input wire logic [CHANNELS-1:0][1:0] xfer_unit_size_o,
  input wire logic [CHANNELS-1:0] xfer_burst_o,
  input wire logic irq_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  logic busy_ff;
  logic evt_ff;
  logic evt2_ff;
  // Delayed causes; an output may react one or two edges late
  always_ff @(posedge mclk_i) begin
    busy_ff <= reset_n_i & (wr_i | addr_fault_i | nmi_i);
    evt_ff <= reset_n_i & ((|xfer_ack_i) | addr_fault_i | nmi_i | wr_i);
    evt2_ff <= evt_ff;
  end
  function automatic logic step_ok(input logic [31:0] n, p,
      input logic [1:0] s);
    step_ok = n == p || n == p + (32'h1 << s) || n == p - (32'h1 << s);
  endfunction
  sequence steal_ack;
    xfer_ack_i[0] && !xfer_burst_o[0];
  endsequence
  sequence quiet_req;
    xfer_req_o[0] && !xfer_ack_i[0] && !busy_ff
      && !(wr_i || addr_fault_i || nmi_i);
  endsequence
  glob_high_zero_a: assert property (
    rd_i && addr_i == `OFF_GLOBAL |=> rdata_o[31:3] == '0)
    else $error("global upper bits not zero");
  steal_gap_a: assert property (steal_ack |=> !xfer_req_o[0])
    else $error("cycle steal kept request");
  req_hold_a: assert property (quiet_req |=> xfer_req_o[0])
    else $error("request dropped without ack");
  fault_block_a: assert property (
    addr_fault_i || nmi_i |-> ##3 xfer_req_o == '0)
    else $error("request despite halt flag");
  src_step_a: assert property (
    xfer_ack_i[0] && !wr_i |=> step_ok(xfer_src_addr_o[0],
      $past(xfer_src_addr_o[0]), $past(xfer_unit_size_o[0])))
    else $error("bad source step");
  dst_step_a: assert property (
    xfer_ack_i[0] && !wr_i |=> step_ok(xfer_dst_addr_o[0],
      $past(xfer_dst_addr_o[0]), $past(xfer_unit_size_o[0])))
    else $error("bad destination step");
  src_hold_a: assert property (
    !xfer_ack_i[0] && !wr_i |=> $stable(xfer_src_addr_o[0]))
    else $error("source moved without ack");
  irq_fall_a: assert property (
    $fell(irq_o) |-> $past(rd_i) || $past(wr_i))
    else $error("interrupt fell without access");
  irq_rise_a: assert property (
    $rose(irq_o) |-> evt_ff || evt2_ff)
    else $error("interrupt rose without event");
endmodule
bind dma_channel_control_regs dma_cc_chk #(.CHANNELS(CHANNELS)) chk_i (
  .mclk_i, .reset_n_i, .addr_i, .wr_i, .rd_i, .rdata_o, .addr_fault_i,
  .nmi_i, .xfer_ack_i, .xfer_req_o, .xfer_src_addr_o, .xfer_dst_addr_o,
  .xfer_unit_size_o, .xfer_burst_o, .irq_o);

// >>> testbench/dma_channel_control_regs_tb.sv
`timescale 1ns/100ps
`include "dma_cc_params.svh"
module dma_channel_control_regs_tb;
  logic mclk_i = 0, reset_n_i = 0, wr_i = 0, rd_i = 0, irq_o;
  logic [31:0] addr_i = 0, wdata_i = 0, rdata_o, rd_v;
  logic [1:0] pin_n = 2'h3, ack, req, single, todev;
  logic [7:0] srcs = 0;
  logic af = 0, nm = 0, sb = 0, slow = 0;
  int n_errors = 0, num_checks = 0;
  always #4 mclk_i = ~mclk_i;
  dma_channel_control_regs uut (.mclk_i, .reset_n_i, .addr_i, .wdata_i,
    .wr_i, .rd_i, .rdata_o, .transfer_request_pin_n_i(pin_n),
    .timer0_match_req_i(srcs[0]), .timer1_match_req_i(srcs[1]),
    .timer2_match_req_i(srcs[2]), .converter_end_req_i(srcs[3]),
    .serial0_tx_req_i(srcs[4]), .serial0_rx_req_i(srcs[5]),
    .serial1_tx_req_i(srcs[6]), .serial1_rx_req_i(srcs[7]),
    .addr_fault_i(af), .nmi_i(nm), .standby_i(sb), .xfer_ack_i(ack),
    .xfer_req_o(req), .xfer_src_addr_o(), .xfer_dst_addr_o(),
    .xfer_unit_size_o(), .xfer_single_o(single),
    .xfer_to_device_o(todev), .xfer_burst_o(), .irq_o);
  xfer_engine_model eng (.mclk_i, .reset_n_i, .req_i(req), .slow_i(slow),
    .ack_o(ack));
  ////////////////////////////////////////////////////////////////////////
  task give_verdict;
    if (n_errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] g, e, input string m);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value at %0t: %s %h not %h", $time, m, g, e);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  task wr(input logic [31:0] a, d);
    @(posedge mclk_i);
    wr_i <= 1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge mclk_i);
    wr_i <= 0;
  endtask
  task rd(input logic [31:0] a);
    @(posedge mclk_i);
    rd_i <= 1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 0;
    #1 rd_v = rdata_o;
  endtask
  // Kind 0/1 waits for a channel request, 2 for the ch0 ack
  task wait_on(input int k);
    int i;
    for (i = 0; i < 60 && (k < 2 ? req[k] : ack[0]) !== 1'b1; i++) cyc(1);
    if ((k < 2 ? req[k] : ack[0]) !== 1'b1) begin
      n_errors++;
      $display("wrong value at %0t: handshake timeout", $time);
      give_verdict();
    end
  endtask
  task wait_done(input logic [31:0] a);
    int i;
    rd_v = 0;
    for (i = 0; i < 30 && rd_v[1] !== 1'b1; i++) rd(a);
    chk(rd_v[1], 1, "done flag");
    if (rd_v[1] !== 1'b1) give_verdict();
  endtask
  task pulse_sb;
    @(posedge mclk_i) sb <= 1;
    @(posedge mclk_i) sb <= 0;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task t_reset;
    cyc(5);
    @(posedge mclk_i) reset_n_i <= 1;
    rd(`OFF_CTRL0);
    chk(rd_v, 0, "ctrl0 reset");
    rd(`OFF_CTRL0 + `CH_STRIDE);
    chk(rd_v, 0, "ctrl1 reset");
    rd(`OFF_GLOBAL);
    chk(rd_v, 0, "global reset");
    rd(32'hffff8700);
    chk(rd_v, 0, "unmapped");
  endtask
  task t_fields;
    wr(`OFF_CTRL0, 32'hffffffff);
    rd(`OFF_CTRL0);
    chk(rd_v, `CTRL_WR_MASK, "ctrl fields");
    wr(`OFF_CTRL0, 0);
    wr(`OFF_GLOBAL, 32'hffff);
    rd(`OFF_GLOBAL);
    chk(rd_v, 1, "global write");
  endtask
  task t_auto;
    wr(`OFF_MASK, 1);
    wr(`OFF_SRC0, 32'h100);
    wr(`OFF_DST0, 32'h200);
    wr(`OFF_CNT0, 3);
    slow <= 1;
    wr(`OFF_CTRL0, 32'h942d);
    wait_on(2);
    cyc(1);
    #1 chk(req[0], 1, "burst hold");
    wait_done(`OFF_CTRL0);
    rd(`OFF_SRC0);
    chk(rd_v, 32'h106, "src step");
    rd(`OFF_DST0);
    chk(rd_v, 32'h1fa, "dst step");
    rd(`OFF_CNT0);
    chk(rd_v, 0, "count");
    chk(irq_o, 1, "irq set");
    wr(`OFF_MASK, 0);
    #1 chk(irq_o, 0, "irq masked");
    wr(`OFF_MASK, 1);
    rd(`OFF_STATUS);
    chk(rd_v, 1, "status");
    chk(irq_o, 0, "irq cleared");
    wr(`OFF_CTRL0, 32'h942d);
    rd(`OFF_CTRL0);
    chk(rd_v, 32'h942d, "done clear");
    slow <= 0;
  endtask
  task t_flags(input int b);
    @(posedge mclk_i) if (b == 2) af <= 1; else nm <= 1;
    @(posedge mclk_i) {af, nm} <= 2'h0;
    wr(`OFF_CNT0, 1);
    wr(`OFF_CTRL0, 32'h401);
    cyc(5);
    chk(req[0], 0, "halted");
    wr(`OFF_GLOBAL, 1);
    rd(`OFF_GLOBAL);
    chk(rd_v, 1 | 1 << b, "clear needs read");
    wr(`OFF_GLOBAL, 32'h7);
    rd(`OFF_GLOBAL);
    chk(rd_v, 1 | 1 << b, "one ignored");
    wr(`OFF_GLOBAL, 1);
    rd(`OFF_GLOBAL);
    chk(rd_v, 1, "flag cleared");
    wait_on(0);
    wait_done(`OFF_CTRL0);
    pulse_sb();
    rd(`OFF_CTRL0);
    chk(rd_v, 32'h401, "standby clear");
  endtask
  task t_srcs;
    logic [3:0] code [8] = '{4'h6, 4'h7, 4'h8, 4'hb, 4'hc, 4'hd, 4'he,
      4'hf};
    for (int i = 0; i < 8; i++) begin
      // Count last, so nothing starts under the previous code
      wr(`OFF_CTRL0, {20'h0, code[i], 8'h01});
      wr(`OFF_CNT0, 1);
      @(posedge mclk_i) srcs <= ~(8'h1 << i);
      @(posedge mclk_i) srcs <= 0;
      cyc(4);
      chk(req[0], 0, "other source");
      @(posedge mclk_i) srcs <= 8'h1 << i;
      @(posedge mclk_i) srcs <= 0;
      wait_on(0);
      wait_done(`OFF_CTRL0);
      pulse_sb();
    end
    wr(`OFF_CTRL0, 32'h101);
    // Nonzero count, so only the barred code can hold it back
    wr(`OFF_CNT0, 1);
    @(posedge mclk_i) {srcs, pin_n} <= {8'hff, 2'h0};
    cyc(8);
    chk(req[0], 0, "barred code");
    {srcs, pin_n} <= {8'h0, 2'h3};
    wr(`OFF_CTRL0, 0);
  endtask
  task t_pin;
    wr(`OFF_CTRL0 + `CH_STRIDE, 32'h340);
    #1 chk(single[1], 1, "single from dev");
    chk(todev[1], 0, "dir from dev");
    wr(`OFF_CNT0 + `CH_STRIDE, 2);
    wr(`OFF_CTRL0 + `CH_STRIDE, 32'h241);
    #1 chk(todev[1], 1, "dir to dev");
    @(posedge mclk_i) pin_n[1] <= 0;
    wait_on(1);
    cyc(12);
    chk(req[1], 0, "edge once");
    @(posedge mclk_i) pin_n[1] <= 1;
    cyc(5);
    pin_n[1] <= 0;
    wait_on(1);
    wr(`OFF_CNT0, 1);
    wr(`OFF_CTRL0, 32'h001);
    @(posedge mclk_i) pin_n[0] <= 0;
    wait_on(0);
    chk(single[0], 0, "dual mode");
    pin_n <= 2'h3;
  endtask
  initial begin
    t_reset();
    t_fields();
    t_auto();
    t_flags(2);
    t_flags(1);
    t_srcs();
    t_pin();
    give_verdict();
  end
endmodule
